/* File: core/psmc_pkg.sv */
package psmc_pkg;

  // ***************************************************
  // register map (word aligned byte addresses)
  // ***************************************************
  localparam logic [5:0] ADDR_IRQ_GLOBAL = 6'h00;
  localparam logic [5:0] ADDR_IRQ_EN0    = 6'h04;
  localparam logic [5:0] ADDR_IRQ_REQ0   = 6'h18;
  localparam logic [5:0] ADDR_THROTTLE   = 6'h2C;
  localparam logic [5:0] ADDR_OSC_FORCE  = 6'h30;
  localparam logic [5:0] ADDR_STATUS     = 6'h34;
  localparam int         NUM_IRQ_REGS    = 5;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int BIT_GIE       = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE      = 6;
  localparam int BIT_EDGE      = 0;
  localparam int BIT_IDLE_SEL  = 7;
  localparam int BIT_DOZE_EN   = 6;
  localparam int BIT_ROI       = 5;
  localparam int BIT_DOE       = 4;
  localparam int BIT_FAST_OSC  = 6;
  localparam int BIT_SLOW_OSC  = 4;
  localparam int BIT_SEC_OSC   = 3;
  localparam int BIT_PD        = 3;
  localparam int BIT_TO        = 4;

  localparam logic [7:0] THROTTLE_MASK  = 8'hF7;
  localparam logic [7:0] GLOBAL_MASK    = 8'hC1;
  localparam logic [7:0] OSC_FORCE_MASK = 8'h58;
  localparam logic [7:0] REQ0_MASK      = 8'h31;
  localparam logic [7:0] RESET_ZERO     = 8'h00;

  // ***************************************************
  // timing: oscillator start-up delay
  // ***************************************************
  localparam int OST_PERIODS = 1024;

  typedef enum logic [1:0] {
    PSMC_RUN   = 2'b00,
    PSMC_IDLE  = 2'b01,
    PSMC_SLEEP = 2'b11,
    PSMC_OST   = 2'b10
  } psmc_mode_e;

  typedef struct packed {
    logic sleep_instr;
    logic return_from_irq_instr;
  } psmc_cpu_s;

  typedef struct packed {
    logic fast_osc;
    logic slow_osc;
    logic sec_osc;
  } psmc_osc_s;

endpackage

/* File: core/psmc_top.sv */
// How it works
// [RULE_01] doze: cpu gets one instruction cycle every N, idle for N-1
// [RULE_02] code 001 gives 1:4, code 100 gives 1:32
// [RULE_03] peripheral clock enable and oscillators keep running during doze
// [RULE_04] interrupt with recover_on_irq clear keeps doze rate
// [RULE_05] interrupt with recover_on_irq set clears doze_enable, full speed
// [RULE_06] return from interrupt with doze_on_exit set re-enables doze
// [RULE_07] sleep instruction enters sleep if idle_select 0, idle if 1
// [RULE_08] any interrupt ends idle even with gie clear; idle_select kept
// [RULE_09] interrupt ending idle with recover_on_irq set restores full speed
// [RULE_10] watchdog timeout in idle wakes, no reset, doze unchanged
// [RULE_11] sleep entry stops clocks, clears pd, sets to, clears watchdog
// [RULE_12] oscillators stay on in sleep if requested or forced on
// [RULE_13] converter continues on rc clock, else aborts and powers off
// [RULE_14] io pins hold state in sleep unless a peripheral is active
// [RULE_15] resets end sleep by reset; watchdog or irq wake continues
// [RULE_16] every wake from sleep clears the watchdog
// [RULE_17] pending enabled flag with gie clear makes sleep a no-op
// [RULE_18] flag set during sleep instruction: complete, wake, clear watchdog
// [RULE_19] crystal wake waits 1024 oscillator periods before executing
// [RULE_20] interrupt flags set regardless of enable bits
// [RULE_21] other doze codes follow power of two from 1:2 to 1:256
// [RULE_22] irq wake with gie set: forced no-ops then vector; else in-line
module psmc_top
  import psmc_pkg::*;
#(
  parameter int OST_CYCLES = OST_PERIODS,
  parameter int NOP_CYCLES = 2
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire psmc_cpu_s   cpu_evt,
  input  wire logic [39:0] irq_events,
  input  wire logic        wdt_timeout,
  input  wire psmc_osc_s   periph_osc_req,
  input  wire logic        converter_rc_clock,
  input  wire logic        converter_on,
  input  wire logic        crystal_mode,
  input  wire logic        pin_periph_active,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             sys_clk_en,
  output psmc_osc_s        osc_run,
  output logic             converter_run,
  output logic             converter_abort,
  output logic             io_hold,
  output logic             wdt_clear,
  output logic             irq_vector,
  output logic             irq_wake,
  output logic             power_down_flag,
  output logic             timeout_flag
);

  initial begin
    if (OST_CYCLES < 1 || OST_CYCLES > 65535 || NOP_CYCLES < 1 || NOP_CYCLES > 2) begin
      $error("psmc_top: unsupported parameter");
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  logic [7:0]  global_q;
  logic [7:0]  en_q  [NUM_IRQ_REGS];
  logic [7:0]  req_q [NUM_IRQ_REGS];
  logic [7:0]  throttle_q;
  logic [7:0]  osc_force_q;
  logic        pd_q;
  logic        to_q;
  logic [39:0] ev_s1_q;
  logic [39:0] ev_s2_q;
  logic        wdt_s1_q;
  logic        wdt_s2_q;
  logic        ack_q;
  psmc_mode_e  mode_q;
  logic [7:0]  doze_cnt_q;
  logic [15:0] ost_cnt_q;
  logic [1:0]  nop_cnt_q;

  logic        wr;
  logic        rd;
  logic [39:0] req_flat;
  logic [39:0] en_flat;
  logic        pending;
  logic        irq_taken;
  logic        sleep_go;
  logic        sleep_nop;
  logic [7:0]  doze_last;
  logic [7:0]  wbyte;

  // a write lands on the edge that sees waitrequest low, not on the first edge
  assign wr    = avs_write && ack_q && avs_byteenable[0];
  assign rd    = avs_read && !ack_q;
  assign wbyte = avs_writedata[7:0];

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ_REGS; g++) begin : g_flat
      assign req_flat[g*8 +: 8] = req_q[g];
      assign en_flat[g*8 +: 8]  = en_q[g];
    end
  endgenerate

  // any source with both enable and flag set; peripheral banks need peripheral_irq_enable
  assign pending = |(req_flat[7:0] & en_flat[7:0])
                 | (global_q[BIT_PERIPHERAL_IRQ_ENABLE] & |(req_flat[39:8] & en_flat[39:8]));
  assign irq_taken = pending && global_q[BIT_GIE] && mode_q == PSMC_RUN;
  assign sleep_go  = cpu_evt.sleep_instr && mode_q == PSMC_RUN;
  assign sleep_nop = sleep_go && pending && !global_q[BIT_GIE]; // RULE_17
  assign doze_last = 8'((9'h001 << ({1'b0, throttle_q[2:0]} + 4'h1)) - 9'h001); // RULE_21

  // ***************************************************
  // synchronisers for pin level events
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_s1_q  <= '0;
      ev_s2_q  <= '0;
      wdt_s1_q <= 1'b0;
      wdt_s2_q <= 1'b0;
    end else begin
      ev_s1_q  <= irq_events;
      ev_s2_q  <= ev_s1_q;
      wdt_s1_q <= wdt_timeout;
      wdt_s2_q <= wdt_s1_q;
    end
  end

  // ***************************************************
  // avalon slave: one wait cycle then answer
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (rd) begin
      avs_readdata <= '0;
      if (avs_address == ADDR_IRQ_GLOBAL) begin
        avs_readdata[7:0] <= global_q;
      end else if (avs_address == ADDR_THROTTLE) begin
        avs_readdata[7:0] <= throttle_q;
      end else if (avs_address == ADDR_OSC_FORCE) begin
        avs_readdata[7:0] <= osc_force_q;
      end else if (avs_address == ADDR_STATUS) begin
        avs_readdata[BIT_PD] <= pd_q;
        avs_readdata[BIT_TO] <= to_q;
      end else begin
        for (int i = 0; i < NUM_IRQ_REGS; i++) begin
          if (avs_address == 6'(ADDR_IRQ_EN0 + 4*i)) begin
            avs_readdata[7:0] <= en_q[i];
          end
          if (avs_address == 6'(ADDR_IRQ_REQ0 + 4*i)) begin
            avs_readdata[7:0] <= req_q[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      global_q    <= RESET_ZERO;
      osc_force_q <= RESET_ZERO;
    end else if (wr) begin
      if (avs_address == ADDR_IRQ_GLOBAL) begin
        global_q <= wbyte & GLOBAL_MASK;
      end
      if (avs_address == ADDR_OSC_FORCE) begin
        osc_force_q <= wbyte & OSC_FORCE_MASK;
      end
    end
  end

  // enables and flags; hardware set wins over a software clear
  generate
    for (g = 0; g < NUM_IRQ_REGS; g++) begin : g_irq
      always_ff @(posedge clk) begin
        if (rst) begin
          en_q[g] <= RESET_ZERO;
        end else if (wr && avs_address == 6'(ADDR_IRQ_EN0 + 4*g)) begin
          en_q[g] <= (g == 0) ? (wbyte & REQ0_MASK) : wbyte;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          req_q[g] <= RESET_ZERO;
        end else if (wr && avs_address == 6'(ADDR_IRQ_REQ0 + 4*g)) begin
          req_q[g] <= ((g == 0) ? (wbyte & REQ0_MASK) : wbyte) | ev_s2_q[g*8 +: 8]; // RULE_20
        end else begin
          req_q[g] <= req_q[g] | (((g == 0) ? REQ0_MASK : 8'hFF) & ev_s2_q[g*8 +: 8]); // RULE_20
        end
      end
    end
  endgenerate

  // ***************************************************
  // throttle register: doze control
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      throttle_q <= RESET_ZERO;
    end else begin
      if (wr && avs_address == ADDR_THROTTLE) begin
        throttle_q <= wbyte & THROTTLE_MASK;
      end
      if (irq_taken && throttle_q[BIT_ROI]) begin
        throttle_q[BIT_DOZE_EN] <= 1'b0; // RULE_05
      end else if (mode_q == PSMC_IDLE && pending && throttle_q[BIT_ROI]) begin
        throttle_q[BIT_DOZE_EN] <= 1'b0; // RULE_09
      end else if (cpu_evt.return_from_irq_instr && throttle_q[BIT_DOE]) begin
        throttle_q[BIT_DOZE_EN] <= 1'b1; // RULE_06
      end
    end
  end

  // ***************************************************
  // mode sequencer
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q    <= PSMC_RUN;
      ost_cnt_q <= '0;
    end else begin
      unique case (mode_q)
        PSMC_RUN: begin
          if (sleep_go && !sleep_nop) begin
            mode_q <= throttle_q[BIT_IDLE_SEL] ? PSMC_IDLE : PSMC_SLEEP; // RULE_07
          end
        end
        PSMC_IDLE: begin
          if (pending || wdt_s2_q) begin
            mode_q <= PSMC_RUN; // RULE_08 RULE_10
          end
        end
        PSMC_SLEEP: begin
          if (pending || wdt_s2_q) begin // RULE_15 RULE_18
            if (crystal_mode) begin
              mode_q    <= PSMC_OST; // RULE_19
              ost_cnt_q <= 16'(OST_CYCLES - 1);
            end else begin
              mode_q <= PSMC_RUN;
            end
          end
        end
        PSMC_OST: begin
          if (ost_cnt_q == '0) begin
            mode_q <= PSMC_RUN;
          end else begin
            ost_cnt_q <= ost_cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // power-down and timeout flags (active-low style status bits)
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end else if (sleep_go && !sleep_nop) begin
      pd_q <= 1'b0; // RULE_11 RULE_18
      to_q <= 1'b1;
    end
  end

  // ***************************************************
  // doze counter: active on count zero
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      doze_cnt_q <= '0;
    end else if (!throttle_q[BIT_DOZE_EN] || doze_cnt_q >= doze_last) begin
      doze_cnt_q <= '0;
    end else begin
      doze_cnt_q <= doze_cnt_q + 8'h01; // RULE_01 RULE_02
    end
  end

  // forced no-op cycles after an interrupt wake with gie set
  always_ff @(posedge clk) begin
    if (rst) begin
      nop_cnt_q <= '0;
      irq_vector <= 1'b0;
    end else begin
      irq_vector <= 1'b0;
      if ((mode_q == PSMC_SLEEP || mode_q == PSMC_IDLE) && pending && global_q[BIT_GIE]) begin
        nop_cnt_q <= 2'(NOP_CYCLES); // RULE_22
      end else if (nop_cnt_q != '0 && mode_q == PSMC_RUN) begin
        nop_cnt_q  <= nop_cnt_q - 2'h1;
        irq_vector <= (nop_cnt_q == 2'h1);
      end
    end
  end

  // ***************************************************
  // clock and side-effect outputs
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      sys_clk_en    <= 1'b1;
    end else begin
      // doze only gates the cpu; peripherals stay at full rate
      cpu_clk_en    <= mode_q == PSMC_RUN
                    && (!throttle_q[BIT_DOZE_EN] || doze_cnt_q == '0); // RULE_01 RULE_04
      periph_clk_en <= mode_q != PSMC_SLEEP && mode_q != PSMC_OST; // RULE_03 RULE_07
      sys_clk_en    <= mode_q != PSMC_SLEEP && mode_q != PSMC_OST; // RULE_11
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_run <= '1;
    end else if (mode_q == PSMC_SLEEP) begin
      osc_run.fast_osc <= periph_osc_req.fast_osc | osc_force_q[BIT_FAST_OSC]; // RULE_12
      osc_run.slow_osc <= periph_osc_req.slow_osc | osc_force_q[BIT_SLOW_OSC]; // RULE_12
      osc_run.sec_osc  <= periph_osc_req.sec_osc  | osc_force_q[BIT_SEC_OSC];  // RULE_12
    end else begin
      osc_run <= '1; // RULE_03
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      converter_run   <= 1'b0;
      converter_abort <= 1'b0;
      io_hold         <= 1'b0;
      wdt_clear       <= 1'b0;
      irq_wake        <= 1'b0;
    end else begin
      converter_abort <= sleep_go && !sleep_nop && !converter_rc_clock; // RULE_13
      converter_run   <= converter_on && (mode_q == PSMC_RUN || mode_q == PSMC_IDLE
                                          || converter_rc_clock); // RULE_13
      io_hold   <= mode_q == PSMC_SLEEP && !pin_periph_active; // RULE_14
      wdt_clear <= (sleep_go && !sleep_nop)                    // RULE_11
                || (mode_q == PSMC_SLEEP && (pending || wdt_s2_q)); // RULE_16
      irq_wake  <= (mode_q == PSMC_SLEEP || mode_q == PSMC_IDLE) && pending;
    end
  end

  assign power_down_flag = pd_q;
  assign timeout_flag    = to_q;

endmodule

/* File: dv/psmc_props.sv */
// ****************
// power mode checker
// ****************
module psmc_props
  import psmc_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      avs_read,
  input wire logic      avs_write,
  input wire logic      avs_waitrequest,
  input wire psmc_osc_s periph_osc_req,
  input wire logic      converter_rc_clock,
  input wire logic      pin_periph_active,
  input wire logic      cpu_clk_en,
  input wire logic      periph_clk_en,
  input wire logic      sys_clk_en,
  input wire psmc_osc_s osc_run,
  input wire logic      converter_abort,
  input wire logic      io_hold,
  input wire logic      wdt_clear,
  input wire logic      irq_wake,
  input wire logic      power_down_flag,
  input wire logic      timeout_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_ANSWER: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("bus answer without request");
  AST_PERIPH_RUN: assert property (sys_clk_en |-> periph_clk_en)
    else $error("peripheral clock stopped while system clock runs");
  AST_SLEEP_CLK: assert property (!sys_clk_en |-> !cpu_clk_en)
    else $error("cpu clocked while system clock stopped");
  AST_SLEEP_FLAGS: assert property ($fell(sys_clk_en) |-> ##[0:2] (!power_down_flag && timeout_flag))
    else $error("status flags wrong on sleep entry");
  AST_WAKE_WDT: assert property ($rose(irq_wake) && !sys_clk_en |-> ##[0:12] wdt_clear)
    else $error("watchdog not cleared on wake");
  // requested oscillators must survive sleep
  AST_OSC_KEEP: assert property (!sys_clk_en && $past(!sys_clk_en) |->
    (osc_run & $past(periph_osc_req)) == $past(periph_osc_req))
    else $error("requested oscillator stopped in sleep");
  AST_CONV_ABORT: assert property (converter_abort |-> !$past(converter_rc_clock))
    else $error("converter aborted on its own rc clock");
  AST_IO_HOLD: assert property (io_hold |-> !$past(pin_periph_active))
    else $error("pins held while a peripheral is active");
endmodule

bind psmc_top psmc_props u_psmc_props (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .periph_osc_req(periph_osc_req),
  .converter_rc_clock(converter_rc_clock), .pin_periph_active(pin_periph_active),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .sys_clk_en(sys_clk_en),
  .osc_run(osc_run), .converter_abort(converter_abort), .io_hold(io_hold),
  .wdt_clear(wdt_clear), .irq_wake(irq_wake), .power_down_flag(power_down_flag),
  .timeout_flag(timeout_flag)
);

/* File: dv/psmc_cpu_model.sv */
// ****************
// cpu core model
// ****************
module psmc_cpu_model
  import psmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cpu_clk_en,
  input  wire logic req_sleep,
  input  wire logic req_return_from_irq_instr,
  output psmc_cpu_s cpu_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sleep_q;
  logic return_from_irq_instr_q;

  // an instruction only retires on a cycle the core is clocked
  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_q  <= 1'b0;
      return_from_irq_instr_q <= 1'b0;
      cpu_evt  <= '0;
    end else begin
      cpu_evt.sleep_instr <= cpu_clk_en && sleep_q;
      cpu_evt.return_from_irq_instr      <= cpu_clk_en && return_from_irq_instr_q;
      sleep_q  <= req_sleep || (sleep_q && !cpu_clk_en);
      return_from_irq_instr_q <= req_return_from_irq_instr || (return_from_irq_instr_q && !cpu_clk_en);
    end
  end
endmodule

/* File: dv/psmc_top_tb.sv */
module psmc_top_tb
  import psmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         OST = 8;
  localparam logic [7:0] DZ  = 8'h01 << BIT_DOZE_EN;
  localparam logic [7:0] IDL = 8'h01 << BIT_IDLE_SEL;
  localparam logic [7:0] RECOVER_ON_IRQ = 8'h01 << BIT_ROI;
  localparam logic [7:0] DOZE_ON_EXIT = 8'h01 << BIT_DOE;
  localparam logic [7:0] GLOBAL_IRQ_ENABLE = 8'h01 << BIT_GIE;
  localparam logic [7:0] ST0 = (8'h01 << BIT_PD) | (8'h01 << BIT_TO);
  localparam logic [7:0] ST1 = 8'h01 << BIT_TO;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  psmc_cpu_s   cpu_evt;
  logic [39:0] irq_events = '0;
  logic        wdt_timeout = 1'b0;
  psmc_osc_s   osc_req = '0;
  logic        rc_clk = 1'b0;
  logic        pin_act = 1'b0;
  logic        xtal = 1'b1;
  logic        irq_vector;
  int          vectors = 0;
  logic        cpu_clk_en;
  logic        sys_clk_en;
  logic        req_sleep = 1'b0;
  logic        req_return_from_irq_instr = 1'b0;
  logic [31:0] expq[$];
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;

  always #12.5 clk = ~clk;

  psmc_top #(.OST_CYCLES(OST), .NOP_CYCLES(2)) u_psmc_top (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_evt(cpu_evt),
    .irq_events(irq_events), .wdt_timeout(wdt_timeout), .periph_osc_req(osc_req),
    .converter_rc_clock(rc_clk), .converter_on(1'b1), .crystal_mode(xtal),
    .pin_periph_active(pin_act), .cpu_clk_en(cpu_clk_en), .periph_clk_en(),
    .sys_clk_en(sys_clk_en), .osc_run(), .converter_run(), .converter_abort(),
    .io_hold(), .wdt_clear(), .irq_vector(irq_vector), .irq_wake(), .power_down_flag(),
    .timeout_flag()
  );
  psmc_cpu_model u_psmc_cpu_model (
    .clk(clk), .rst(rst), .cpu_clk_en(cpu_clk_en), .req_sleep(req_sleep),
    .req_return_from_irq_instr(req_return_from_irq_instr), .cpu_evt(cpu_evt)
  );

  // ****************
  // checking
  // ****************
  task automatic fail(input string m);
    mismatches++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (expq.size() == 0) fail("read without note");
      else cmp(avs_readdata, expq.pop_front(), "read data");
    end
  end
  always @(posedge clk) begin
    if (irq_vector === 1'b1) vectors++;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************
  // stimulus tasks
  // ****************
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) fail("bus timeout");
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic irq(input logic v);
    @(posedge clk);
    irq_events[0] <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic unirq;
    irq(1'b0);
    bus(1'b1, ADDR_IRQ_REQ0, 8'h00);
  endtask
  task automatic cpu_req(input logic s);
    @(posedge clk);
    req_sleep  <= s;
    req_return_from_irq_instr <= !s;
    @(posedge clk);
    req_sleep  <= 1'b0;
    req_return_from_irq_instr <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic await_cpu(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cpu_clk_en !== 1'b1 && k < 600);
  endtask

  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(32'h9BE9CAF8));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_THROTTLE, 8'h00);
    rd(6'h3C, 8'h00);
    bus(1'b1, ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, ST0);
    irq(1'b1);
    rd(ADDR_IRQ_REQ0, 8'h01);
    bus(1'b1, ADDR_IRQ_EN0, 8'h01);
    cpu_req(1'b1);
    cmp({31'h0, sys_clk_en}, 32'h1, "sleep ran despite pending flag");
    rd(ADDR_STATUS, ST0);
    unirq();
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, ADDR_THROTTLE, DZ | 8'(c));
      await_cpu(n);
      await_cpu(n);
      await_cpu(n);
      cmp(32'(n), 32'(2 << c), "doze period");
    end
    bus(1'b1, ADDR_IRQ_GLOBAL, GLOBAL_IRQ_ENABLE);
    bus(1'b1, ADDR_THROTTLE, DZ | RECOVER_ON_IRQ | DOZE_ON_EXIT | 8'h01);
    irq(1'b1);
    rd(ADDR_THROTTLE, RECOVER_ON_IRQ | DOZE_ON_EXIT | 8'h01);
    unirq();
    cpu_req(1'b0);
    rd(ADDR_THROTTLE, DZ | RECOVER_ON_IRQ | DOZE_ON_EXIT | 8'h01);
    bus(1'b1, ADDR_THROTTLE, DZ | 8'h01);
    irq(1'b1);
    rd(ADDR_THROTTLE, DZ | 8'h01);
    unirq();
    bus(1'b1, ADDR_IRQ_GLOBAL, 8'h00);
    bus(1'b1, ADDR_THROTTLE, IDL | DZ | RECOVER_ON_IRQ | 8'h01);
    cpu_req(1'b1);
    cmp({30'h0, cpu_clk_en, sys_clk_en}, 32'h1, "idle clocks");
    irq(1'b1);
    await_cpu(n);
    rd(ADDR_THROTTLE, IDL | RECOVER_ON_IRQ | 8'h01);
    unirq();
    bus(1'b1, ADDR_THROTTLE, IDL | DZ | RECOVER_ON_IRQ | 8'h01);
    cpu_req(1'b1);
    @(posedge clk);
    wdt_timeout <= 1'b1;
    repeat (4) @(posedge clk);
    wdt_timeout <= 1'b0;
    await_cpu(n);
    cmp({31'h0, cpu_clk_en}, 32'h1, "watchdog wake in idle");
    rd(ADDR_THROTTLE, IDL | DZ | RECOVER_ON_IRQ | 8'h01);
    for (int k = 0; k < 2; k++) begin
      rc_clk  <= 1'($urandom);
      pin_act <= 1'($urandom);
      osc_req <= 3'($urandom);
      xtal    <= (k == 0);
      bus(1'b1, ADDR_IRQ_GLOBAL, (k == 0) ? 8'h00 : GLOBAL_IRQ_ENABLE);
      bus(1'b1, ADDR_THROTTLE, 8'h00);
      cpu_req(1'b1);
      cmp({31'h0, sys_clk_en}, 32'h0, "sleep entry");
      irq(1'b1);
      await_cpu(n);
      cmp(32'(n), (k == 0) ? 32'(OST + 2) : 32'h2, "start-up delay");
      rd(ADDR_STATUS, ST1);
      cmp(32'(vectors), 32'(k), "vector after wake");
      unirq();
    end
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_STATUS, ST0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail("timeout");
    test_done();
  end
endmodule
